/* File: dv/rf_reader_model.sv */
// Reader-side model that finishes a wait-extension request after a delay
`timescale 1ns/100ps
`default_nettype none
module rf_reader_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Extension handshake
  input wire logic [3:0] dly,
  input wire logic req,
  output logic done
);
  logic [3:0] cnt_q;
  // Request frame goes out only while the request is held
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= 4'h0;
      done <= 1'b0;
    end else if (req && !done && cnt_q == dly) begin
      cnt_q <= 4'h0;
      done <= 1'b1;
    end else begin
      cnt_q <= (req && !done) ? cnt_q + 4'h1 : 4'h0;
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: dv/rf_response_timeout_wtx_ctrl_tb.sv */
// Self-checking bench for the response timer and control word
`timescale 1ns/100ps
`default_nettype none
module rf_response_timeout_wtx_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, v = 1'b0, hst = 1'b0, upd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdat, got;
  logic [5:0] mult = 6'h2A, mout;
  logic [3:0] fwi, dly = 4'h3;
  logic wdone, wreq, srv = 1'b0, wdog = 1'b0, busy = 1'b0, acc, drp, aack;
  logic io, ioe, hrdy, wact_n, stby, srst, a_acc, a_drp, a_ack, seen;
  logic [1:0] pins;
  int errors = 0, n_tests = 0;
  always #10 clk = ~clk;
  rf_response_timeout_wtx_ctrl #(.RESP_TIMEOUT_CYC(20)) rf_response_timeout_wtx_ctrl_inst (
    .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd),
    .REG_RDATA(rdat), .RF_CMD_VALID(v), .RF_CMD_HOST(hst), .RF_CMD_UPDATE(upd),
    .RF_ACCEPT(acc), .RF_DROP(drp), .AUTO_ACK(aack), .FWI_CODE(fwi), .WTX_MULT(mult),
    .WTX_DONE(wdone), .WTX_REQ(wreq), .WTX_MULT_OUT(mout), .HOST_SERVICED(srv),
    .INT_O(io), .INT_OE(ioe), .HOST_READY(hrdy), .WTX_ACTIVE_N(wact_n), .WDOG_EN(wdog),
    .SERIAL_BUSY(busy), .STANDBY(stby), .SOFT_RST_O(srst));
  rf_reader_model rf_reader_model_inst (.CLK(clk), .RST(rst), .dly(dly), .req(wreq),
    .done(wdone));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrb(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdb(input logic [15:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdat;
  endtask
  task automatic cmd(input logic h, input logic u);
    @(posedge clk);
    v <= 1'b1; hst <= h; upd <= u;
    @(negedge clk);
    a_acc = acc; a_drp = drp; a_ack = aack;
    @(posedge clk);
    v <= 1'b0;
  endtask
  task automatic service();
    @(posedge clk);
    srv <= 1'b1;
    @(posedge clk);
    srv <= 1'b0;
  endtask
  // Watches the extension request over n cycles; pins are taken while it stands
  task automatic watch(input int n);
    seen = 1'b0;
    pins = 2'b11;
    repeat (n) begin
      @(negedge clk);
      if (wreq === 1'b1 && !seen) pins = {hrdy, wact_n};
      if (wreq === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk("fwi", fwi, rsp_timer_pkg::FWI_MAX);
    chk("int_oe_rst", ioe, 1'b0);
    cmd(1'b1, 1'b0);
    chk("drop_rf_off", {a_acc, a_drp}, 2'b01);
    wrb(16'hFFFF, 8'hFF);
    rdb(16'hFFFF);
    chk("ctrl_hi", got, 8'h01);
    wrb(16'hFFFE, 8'h86);
    rdb(16'hFFFE);
    chk("ctrl_lo", got, 8'h86);
    rdb(16'h1234);
    chk("unmapped", got, 8'h00);
    $display("done regs");
  endtask
  task automatic t_service();
    cmd(1'b1, 1'b0);
    chk("accept", {a_acc, a_drp, a_ack}, 3'b100);
    @(negedge clk);
    chk("int_low", {io, ioe}, 2'b01);
    repeat (5) @(posedge clk);
    service();
    watch(40);
    chk("no_wtx", seen, 1'b0);
    chk("int_idle", io, 1'b1);
    $display("done service");
  endtask
  task automatic t_wtx(input logic [3:0] d);
    dly <= d;
    cmd(1'b1, 1'b0);
    watch(30);
    chk("wtx_req", seen, 1'b1);
    chk("pins_low", pins, 2'b00);
    chk("mult", mout, mult);
    cmd(1'b1, 1'b0);
    chk("drop_pend", {a_acc, a_drp}, 2'b01);
    repeat (20) @(negedge clk);
    chk("pins_high", {wreq, hrdy, wact_n}, 3'b011);
    watch(40);
    chk("no_second", seen, 1'b0);
    service();
    $display("done wtx");
  endtask
  task automatic t_auto();
    wrb(16'hFFFF, 8'h01);
    wrb(16'hFFFE, 8'h1E);
    cmd(1'b1, 1'b1);
    chk("auto_ack", {a_acc, a_ack}, 2'b11);
    @(negedge clk);
    chk("int_high", {io, ioe}, 2'b11);
    service();
    @(negedge clk);
    chk("int_drive_idle", {io, ioe}, 2'b01);
    $display("done auto");
  endtask
  task automatic t_power();
    wrb(16'hFFFE, 8'h40);
    repeat (2) @(negedge clk);
    chk("standby", stby, 1'b1);
    @(posedge clk);
    busy <= 1'b1;
    repeat (2) @(negedge clk);
    chk("no_standby", stby, 1'b0);
    @(posedge clk);
    busy <= 1'b0;
    wdog <= 1'b1;
    repeat (2) @(negedge clk);
    chk("wdog_standby", stby, 1'b0);
    wrb(16'hFFFE, 8'h01);
    @(negedge clk);
    chk("srst", srst, 1'b1);
    rdb(16'hFFFF);
    chk("ctrl_clr", got, 8'h00);
    $display("done power");
  endtask
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_service();
    t_wtx(4'h0);
    t_wtx(4'h9);
    t_auto();
    t_power();
    finish_test();
  end
endmodule
`default_nettype wire

/* File: hw/rf_response_timeout_wtx_ctrl.sv */
// Host response timer, wait-extension sequencer and general control word
// Operation
// RQ1: Advertise frame waiting time integer 8
// RQ2: Internal timer defaults near 55 ms
// RQ3: Host command loads state, raises interrupt
// RQ4: Start timer when interrupt is raised
// RQ5: Expiry unserviced drives both pins low
// RQ6: Indicator held low during extension request
// RQ7: Copy multiplier into outgoing request field
// RQ8: After sending, release both pins high
// RQ9: Ignore reader frames while command pending
// RQ10: Expiry during extended wait does nothing
// RQ11: Host services within extended period
// RQ12: Low byte even address, high odd
// RQ13: Control at FFFE/FFFF, bits 15-9 zero
// RQ14: Bit 8 auto-acknowledges update commands
// RQ15: Host drains buffer fast with auto-ack
// RQ16: Standby only when all activity idle
// RQ17: Bit 1 gates all reader commands
// RQ18: Bit 2 off floats interrupt pin
// RQ19: Bit 3 selects interrupt polarity
// RQ20: Bit 0 write resets, reads zero
// RQ21: Timer stops on service, restarts per command
`timescale 1ns/100ps
`default_nettype none
module rf_response_timeout_wtx_ctrl #(
  parameter int unsigned RESP_TIMEOUT_CYC = rsp_timer_pkg::RESP_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Byte register port
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Reader command side
  input wire logic RF_CMD_VALID,
  input wire logic RF_CMD_HOST,
  input wire logic RF_CMD_UPDATE,
  output logic RF_ACCEPT,
  output logic RF_DROP,
  output logic AUTO_ACK,
  output logic [3:0] FWI_CODE,
  // Wait-extension request
  input wire logic [5:0] WTX_MULT,
  input wire logic WTX_DONE,
  output logic WTX_REQ,
  output logic [5:0] WTX_MULT_OUT,
  // Host side
  input wire logic HOST_SERVICED,
  output logic INT_O,
  output logic INT_OE,
  output logic HOST_READY,
  output logic WTX_ACTIVE_N,
  // Power and reset
  input wire logic WDOG_EN,
  input wire logic SERIAL_BUSY,
  output logic STANDBY,
  output logic SOFT_RST_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rsp_timer_pkg::seq_state_t state_q;
  rsp_timer_pkg::seq_state_t state_d;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic pending_q;
  logic pending_d;
  logic [5:0] mult_q;
  logic [5:0] mult_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic srst_q;
  logic srst_d;
  logic stby_q;
  logic stby_d;
  logic wr_lo;
  logic wr_hi;
  logic accept;
  logic host_cmd;
  logic tmr_run;
  logic tmr_exp;

  function automatic logic [7:0] read_byte(input logic [15:0] addr, input logic [15:0] c);
    if (addr == rsp_timer_pkg::GEN_CTRL_LO_ADDR) begin
      read_byte = c[7:0]; // RQ12
    end else if (addr == rsp_timer_pkg::GEN_CTRL_HI_ADDR) begin
      read_byte = c[15:8];
    end else begin
      read_byte = 8'h00;
    end
  endfunction

  assign wr_lo = REG_WR && (REG_ADDR == rsp_timer_pkg::GEN_CTRL_LO_ADDR);
  assign wr_hi = REG_WR && (REG_ADDR == rsp_timer_pkg::GEN_CTRL_HI_ADDR);
  // A second frame cannot be buffered while the first is unserviced, and none is taken
  // while the extension request is still going out, so no command loses its own timer
  assign accept = RF_CMD_VALID && ctrl_q[rsp_timer_pkg::RF_IFACE_EN_BIT] && !pending_q &&
                  (state_q != rsp_timer_pkg::ST_WTX); // RQ9 RQ17
  assign host_cmd = accept && RF_CMD_HOST;

  // ----------------------------------------------------------------
  // Response timer
  // ----------------------------------------------------------------
  rsp_countdown #(
    .PERIOD_CYC(RESP_TIMEOUT_CYC) // RQ2
  ) u_timer (
    .CLK(CLK),
    .RST(RST),
    .start(host_cmd), // RQ4 RQ21
    .stop(HOST_SERVICED || srst_q), // RQ21
    .running(tmr_run),
    .expire(tmr_exp)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    pending_d = pending_q;
    mult_d = mult_q;
    rdata_d = rdata_q;
    srst_d = wr_lo && REG_WDATA[rsp_timer_pkg::SOFT_RESET_BIT]; // RQ20
    if (REG_RD) begin
      rdata_d = read_byte(REG_ADDR, ctrl_q);
    end
    if (wr_lo) begin
      ctrl_d[7:0] = REG_WDATA & rsp_timer_pkg::GEN_CTRL_MASK[7:0]; // RQ20
    end
    if (wr_hi) begin
      ctrl_d[15:8] = REG_WDATA & rsp_timer_pkg::GEN_CTRL_MASK[15:8]; // RQ13
    end
    if (HOST_SERVICED) begin
      pending_d = 1'b0;
    end
    if (host_cmd) begin
      pending_d = 1'b1; // RQ3
    end
    case (state_q)
      rsp_timer_pkg::ST_IDLE: begin
        if (host_cmd) begin
          state_d = rsp_timer_pkg::ST_WAIT_HOST;
        end
      end
      rsp_timer_pkg::ST_WAIT_HOST: begin
        if (HOST_SERVICED) begin
          state_d = rsp_timer_pkg::ST_IDLE;
        end else if (tmr_exp) begin
          state_d = rsp_timer_pkg::ST_WTX; // RQ5
          mult_d = WTX_MULT; // RQ7
        end
      end
      rsp_timer_pkg::ST_WTX: begin
        if (WTX_DONE) begin
          state_d = pending_d ? rsp_timer_pkg::ST_EXTENDED : rsp_timer_pkg::ST_IDLE; // RQ8
        end
      end
      rsp_timer_pkg::ST_EXTENDED: begin
        // Only service or a soft reset ends the wait; a timer expiry is deliberately ignored
        if (!pending_q) begin
          // A command taken in the cycle the wait ends must still be tracked
          state_d = host_cmd ? rsp_timer_pkg::ST_WAIT_HOST : rsp_timer_pkg::ST_IDLE; // RQ10
        end
      end
      default: begin
        state_d = rsp_timer_pkg::ST_IDLE;
      end
    endcase
    // Standby waits for the reader interface, the watchdog and the serial port to be quiet
    stby_d = ctrl_q[rsp_timer_pkg::STANDBY_EN_BIT] && !ctrl_q[rsp_timer_pkg::RF_IFACE_EN_BIT] &&
             !WDOG_EN && !SERIAL_BUSY; // RQ16
    if (srst_q) begin
      state_d = rsp_timer_pkg::ST_IDLE;
      ctrl_d = rsp_timer_pkg::GEN_CTRL_RESET; // RQ20
      pending_d = 1'b0;
      mult_d = 6'h00;
      stby_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= rsp_timer_pkg::ST_IDLE;
      ctrl_q <= rsp_timer_pkg::GEN_CTRL_RESET;
      pending_q <= 1'b0;
      mult_q <= 6'h00;
      rdata_q <= 8'h00;
      srst_q <= 1'b0;
      stby_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      pending_q <= pending_d;
      mult_q <= mult_d;
      rdata_q <= rdata_d;
      srst_q <= srst_d;
      stby_q <= stby_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA = rdata_q;
  assign FWI_CODE = rsp_timer_pkg::FWI_MAX; // RQ1
  assign RF_ACCEPT = accept;
  assign RF_DROP = RF_CMD_VALID && !accept;
  assign AUTO_ACK = accept && RF_CMD_UPDATE && ctrl_q[rsp_timer_pkg::AUTO_ACK_BIT]; // RQ14
  assign WTX_REQ = (state_q == rsp_timer_pkg::ST_WTX);
  assign WTX_MULT_OUT = mult_q;
  assign HOST_READY = (state_q != rsp_timer_pkg::ST_WTX); // RQ5 RQ8
  assign WTX_ACTIVE_N = (state_q != rsp_timer_pkg::ST_WTX); // RQ6
  // Idle level is the inverse of the active level
  assign INT_O = pending_q ~^ ctrl_q[rsp_timer_pkg::INT_HIGH_BIT]; // RQ19
  assign INT_OE = ctrl_q[rsp_timer_pkg::INT_EN_BIT] &&
                  (pending_q || ctrl_q[rsp_timer_pkg::INT_DRIVE_BIT]); // RQ18
  assign STANDBY = stby_q;
  assign SOFT_RST_O = srst_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_fwi_max_code: assert property (FWI_CODE == 4'h8) else $error("fwi not 8"); // RQ1
  a_cmd_raises_int: assert property (host_cmd && !srst_q |=> pending_q && tmr_run) // RQ3
    else $error("host cmd did not raise int");
  a_expire_pins_low: assert property (state_q == rsp_timer_pkg::ST_WAIT_HOST && tmr_exp &&
    !HOST_SERVICED && !srst_q |=> !HOST_READY && !WTX_ACTIVE_N && WTX_REQ) // RQ5
    else $error("pins not low on expiry");
  a_wtx_hold_low: assert property (WTX_REQ && !WTX_DONE && !srst_q |=> !WTX_ACTIVE_N) // RQ6
    else $error("wtx indicator released early");
  a_mult_copied: assert property ($rose(WTX_REQ) |-> WTX_MULT_OUT == $past(WTX_MULT)) // RQ7
    else $error("multiplier not copied");
  a_pins_release: assert property (WTX_REQ && WTX_DONE |=> HOST_READY && WTX_ACTIVE_N) // RQ8
    else $error("pins not released");
  a_busy_drop: assert property (RF_CMD_VALID && pending_q |-> RF_DROP && !RF_ACCEPT) // RQ9
    else $error("frame taken while busy");
  a_no_second_wtx: assert property (state_q == rsp_timer_pkg::ST_EXTENDED |=> !WTX_REQ) // RQ10
    else $error("second extension request");
  a_hi_reserved: assert property (REG_RD && REG_ADDR == rsp_timer_pkg::GEN_CTRL_HI_ADDR
    |=> REG_RDATA[7:1] == 7'h00) else $error("reserved bits nonzero"); // RQ13
  a_auto_ack: assert property (RF_ACCEPT && RF_CMD_UPDATE && ctrl_q[8] |-> AUTO_ACK) // RQ14
    else $error("missing auto ack");
  a_standby_idle: assert property (STANDBY |-> !$past(SERIAL_BUSY) && !$past(WDOG_EN)) // RQ16
    else $error("standby while active");
  a_rf_gate: assert property (!ctrl_q[1] && RF_CMD_VALID |-> !RF_ACCEPT) // RQ17
    else $error("cmd taken with rf off");
  a_int_float: assert property (!ctrl_q[2] |-> !INT_OE) else $error("int pin driven"); // RQ18
  a_int_polarity: assert property (INT_OE && pending_q |-> INT_O == ctrl_q[3]) // RQ19
    else $error("int polarity wrong");
  a_soft_reset: assert property (wr_lo && REG_WDATA[0] |=> SOFT_RST_O ##1 ctrl_q == 16'h0000 &&
    !pending_q) else $error("soft reset failed"); // RQ20
  a_timer_stop: assert property (HOST_SERVICED |=> !tmr_run) else $error("timer kept running"); // RQ21
  a_lo_byte_read: assert property (REG_RD && REG_ADDR == rsp_timer_pkg::GEN_CTRL_LO_ADDR
    |=> REG_RDATA[0] == 1'b0 && REG_RDATA[6] == $past(ctrl_q[6])) // RQ12
    else $error("low byte mapping wrong");

  c_serviced_in_time: cover property (host_cmd ##[1:20] HOST_SERVICED);
  c_wtx_issued: cover property ($rose(WTX_REQ) ##[1:20] WTX_DONE);
  c_extended_serviced: cover property (state_q == rsp_timer_pkg::ST_EXTENDED ##1 !pending_q);
  c_auto_ack: cover property (AUTO_ACK);

endmodule
`default_nettype wire

/* File: hw/rsp_countdown.sv */
// Restartable one-shot countdown that pulses once on expiry
`timescale 1ns/100ps
`default_nettype none
module rsp_countdown #(
  parameter int unsigned PERIOD_CYC = rsp_timer_pkg::RESP_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Control
  input wire logic start,
  input wire logic stop,
  // Status
  output logic running,
  output logic expire
);

  logic [rsp_timer_pkg::TMR_W-1:0] cnt_q;
  logic [rsp_timer_pkg::TMR_W-1:0] cnt_d;
  logic run_q;
  logic run_d;
  logic exp_q;
  logic exp_d;

  localparam int CNT_W = rsp_timer_pkg::TMR_W;
  localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(PERIOD_CYC - 1);

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    // Stop wins so a serviced command never sees a late expiry
    if (stop) begin
      run_d = 1'b0;
      cnt_d = '0;
    end else if (start) begin
      run_d = 1'b1;
      cnt_d = LOAD_VAL;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign running = run_q;
  assign expire = exp_q;

endmodule
`default_nettype wire

/* File: hw/rsp_timer_pkg.sv */
// Constants shared by the response timer and wait-extension control logic
package rsp_timer_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] GEN_CTRL_LO_ADDR = 16'hFFFE;
  localparam logic [15:0] GEN_CTRL_HI_ADDR = 16'hFFFF;
  localparam logic [15:0] GEN_CTRL_RESET = 16'h0000;
  // Stored bits of the control word; bit 0 is a write-only command
  localparam logic [15:0] GEN_CTRL_MASK = 16'h01FE;

  // Field positions inside the 16-bit control word
  localparam int SOFT_RESET_BIT = 0;
  localparam int RF_IFACE_EN_BIT = 1;
  localparam int INT_EN_BIT = 2;
  localparam int INT_HIGH_BIT = 3;
  localparam int INT_DRIVE_BIT = 4;
  localparam int PARITY_MODE_BIT = 5;
  localparam int STANDBY_EN_BIT = 6;
  localparam int AUTO_ACK_BIT = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [3:0] FWI_MAX = 4'h8;
  localparam int FWI_WINDOW_MS = 77;
  localparam int CLK_MHZ = 50;
  localparam int RESP_TIMEOUT_MS = 55;
  // Timeout in clock cycles: milliseconds times 1000 times the clock in MHz
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 22;
  localparam int MULT_W = 6;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_HOST,
    ST_WTX,
    ST_EXTENDED
  } seq_state_t;

endpackage
